// *** t1rx_dev.sv ***
// framer receive end: dual-clock fifo and 16.384 Mbit/s multiplexer
`include "t1rx_params.svh"

module t1rx_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16
) (
  // write side
  input wire logic wr_clk,
  input wire logic wr_rst_n,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [WIDTH-1:0] wr_data,
  // read side
  input wire logic rd_clk,
  input wire logic rd_rst_n,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [WIDTH-1:0] rd_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_bin;
  logic [AW:0] wr_gray;
  logic [AW:0] rd_bin;
  logic [AW:0] rd_gray;
  logic [AW:0] rd_gray_s1;
  logic [AW:0] rd_gray_s2;
  logic [AW:0] wr_gray_s1;
  logic [AW:0] wr_gray_s2;
  logic [AW:0] next_wr_bin;
  logic [AW:0] next_wr_gray;
  logic [AW:0] next_rd_bin;
  logic [AW:0] next_rd_gray;
  logic wr_fire;
  logic rd_fire;

  assign wr_fire = wr_valid && wr_ready;
  assign rd_fire = rd_valid && rd_ready;
  assign next_wr_bin = (AW + 1)'(wr_bin + (AW + 1)'(wr_fire));
  assign next_wr_gray = next_wr_bin ^ (next_wr_bin >> 1);
  assign next_rd_bin = (AW + 1)'(rd_bin + (AW + 1)'(rd_fire));
  assign next_rd_gray = next_rd_bin ^ (next_rd_bin >> 1);
  assign rd_data = mem[rd_bin[AW-1:0]];

  // storage
  always_ff @(posedge wr_clk) begin
    if (wr_fire) begin
      mem[wr_bin[AW-1:0]] <= wr_data;
    end
  end

  // write pointer and registered full
  always_ff @(posedge wr_clk or negedge wr_rst_n) begin
    if (!wr_rst_n) begin
      wr_bin <= '0;
      wr_gray <= '0;
      wr_ready <= 1'b0;
    end else begin
      wr_bin <= next_wr_bin;
      wr_gray <= next_wr_gray;
      wr_ready <= next_wr_gray !=
        {~rd_gray_s2[AW:AW-1], rd_gray_s2[AW-2:0]};
    end
  end

  // read pointer into write domain
  always_ff @(posedge wr_clk or negedge wr_rst_n) begin
    if (!wr_rst_n) begin
      rd_gray_s1 <= '0;
      rd_gray_s2 <= '0;
    end else begin
      rd_gray_s1 <= rd_gray;
      rd_gray_s2 <= rd_gray_s1;
    end
  end

  // read pointer and registered empty
  always_ff @(posedge rd_clk or negedge rd_rst_n) begin
    if (!rd_rst_n) begin
      rd_bin <= '0;
      rd_gray <= '0;
      rd_valid <= 1'b0;
    end else begin
      rd_bin <= next_rd_bin;
      rd_gray <= next_rd_gray;
      rd_valid <= next_rd_gray != wr_gray_s2;
    end
  end

  // write pointer into read domain
  always_ff @(posedge rd_clk or negedge rd_rst_n) begin
    if (!rd_rst_n) begin
      wr_gray_s1 <= '0;
      wr_gray_s2 <= '0;
    end else begin
      wr_gray_s1 <= wr_gray;
      wr_gray_s2 <= wr_gray_s1;
    end
  end
endmodule : t1rx_fifo

module t1rx_dev
  import t1rx_pkg::*;
(
  // system side
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic MUX_EN,
  input wire logic [1:0] MODE_SEL,
  // stream words in
  input wire logic S_VALID,
  output logic S_READY,
  input wire logic [`T1RX_WORD_W-1:0] S_DATA,
  // backplane link
  t1rx_link_if.dev LINK
);
  logic mode_on;
  logic lrst_s1;
  logic lrst_n;
  logic mode_s1;
  logic mode_s2;
  logic sync_s1;
  logic sync_s2;
  logic sync_s3;
  logic aligned;
  logic boundary;
  logic running;
  logic need_word;
  logic rd_valid;
  logic next_bit;
  logic [`T1RX_IDX_W-1:0] bit_idx;
  logic [`T1RX_IDX_W-1:0] next_idx;
  logic [2:0] pos;
  t1rx_octet_type kind;
  t1rx_word_type rd_data;
  t1rx_word_type cur_word;
  t1rx_word_type word_now;

  // mode decode on the system clock
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      mode_on <= 1'b0;
    end else begin
      mode_on <= MUX_EN && (MODE_SEL == `T1RX_MODE_H100);
    end
  end

  // link-side reset release
  always_ff @(posedge LINK.rx_serial_clock_in or negedge RST_N) begin
    if (!RST_N) begin
      lrst_s1 <= 1'b0;
      lrst_n <= 1'b0;
    end else begin
      lrst_s1 <= 1'b1;
      lrst_n <= lrst_s1;
    end
  end

  // words cross into the link clock domain
  t1rx_fifo #(
    .WIDTH(`T1RX_WORD_W),
    .DEPTH(`T1RX_FIFO_DEPTH)
  ) u_fifo (
    .wr_clk(CLK_SYS),
    .wr_rst_n(RST_N),
    .wr_valid(S_VALID),
    .wr_ready(S_READY),
    .wr_data(S_DATA),
    .rd_clk(LINK.rx_serial_clock_in),
    .rd_rst_n(lrst_n),
    .rd_valid(rd_valid),
    .rd_ready(need_word),
    .rd_data(rd_data)
  );

  // mode level and sync pin synchronisers
  always_ff @(posedge LINK.rx_serial_clock_in or negedge lrst_n) begin
    if (!lrst_n) begin
      mode_s1 <= 1'b0;
      mode_s2 <= 1'b0;
      sync_s1 <= 1'b0;
      sync_s2 <= 1'b0;
      sync_s3 <= 1'b0;
    end else begin
      mode_s1 <= mode_on;
      mode_s2 <= mode_s1;
      sync_s1 <= LINK.rx_frame_sync_in;
      sync_s2 <= sync_s1;
      sync_s3 <= sync_s2;
    end
  end

  // leading edge of the sync pulse is the boundary
  assign boundary = sync_s2 && !sync_s3;
  assign running = mode_s2 && (aligned || boundary);
  assign next_idx = boundary ? '0 : `T1RX_IDX_W'(bit_idx + 1'b1);
  assign pos = next_idx[2:0];
  assign kind = t1rx_classify(next_idx[`T1RX_IDX_W-1:3]);
  assign need_word = running && (pos == 3'h0) &&
    (kind == OCT_FBITS || kind == OCT_PAY_HI);
  assign word_now = !need_word ? cur_word : (rd_valid ? rd_data : '0);

  // bit selection within the octet
  always_comb begin
    next_bit = `T1RX_FILL_BIT;
    unique case (kind)
      OCT_FBITS: next_bit = word_now[pos[2:1]];
      OCT_PAY_HI: next_bit = word_now[`T1RX_PAY_MSB - pos[2:1]];
      OCT_PAY_LO: begin
        if (!pos[0]) begin
          next_bit = word_now[`T1RX_PAY_MSB - 4 - pos[2:1]];
        end else begin
          next_bit = word_now[`T1RX_SIG_MSB - pos[2:1]];
        end
      end
      OCT_FILL: next_bit = `T1RX_FILL_BIT;
    endcase
  end

  // frame position
  always_ff @(posedge LINK.rx_serial_clock_in or negedge lrst_n) begin
    if (!lrst_n) begin
      bit_idx <= '0;
      aligned <= 1'b0;
    end else begin
      bit_idx <= next_idx;
      aligned <= mode_s2 && (aligned || boundary);
    end
  end

  // held word for the current octet
  always_ff @(posedge LINK.rx_serial_clock_in or negedge lrst_n) begin
    if (!lrst_n) begin
      cur_word <= '0;
    end else if (need_word) begin
      cur_word <= word_now;
    end
  end

  // serial pin, launched on the rising edge
  always_ff @(posedge LINK.rx_serial_clock_in or negedge lrst_n) begin
    if (!lrst_n) begin
      LINK.rx_serial_data_out <= 1'b0;
    end else begin
      LINK.rx_serial_data_out <= running ? next_bit : 1'b0;
    end
  end
endmodule : t1rx_dev

// *** t1rx_host.sv ***
// terminal equipment end: link clock, frame sync and word recovery
`include "t1rx_params.svh"

module t1rx_host
  import t1rx_pkg::*;
(
  // system side
  input wire logic CLK_SYS,
  input wire logic RST_N,
  // recovered words
  output logic M_VALID,
  output logic M_FIRST,
  output logic [`T1RX_WORD_W-1:0] M_DATA,
  // backplane link
  t1rx_link_if.host LINK
);
  localparam int PH_W = $clog2(2 * `T1RX_LINK_HALF);

  logic [PH_W-1:0] phase;
  logic rise_now;
  logic fall_now;
  logic take_now;
  logic data_s1;
  logic data_s2;
  logic sent_sync;
  logic [`T1RX_IDX_W-1:0] host_idx;
  logic [`T1RX_IDX_W-1:0] dev_idx;
  logic [6:0] octet;
  logic [3:0] pay_hi;
  t1rx_octet_type kind;

  assign rise_now = phase == PH_W'(2 * `T1RX_LINK_HALF - 1);
  assign fall_now = phase == PH_W'(`T1RX_LINK_HALF - 1);
  assign take_now = phase == PH_W'(`T1RX_LINK_HALF);
  assign dev_idx = `T1RX_IDX_W'(host_idx - `T1RX_SYNC_LAG);
  assign kind = t1rx_classify(dev_idx[`T1RX_IDX_W-1:3]);

  // free-running divided link clock
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      phase <= '0;
      LINK.rx_serial_clock_in <= 1'b0;
    end else begin
      phase <= rise_now ? '0 : PH_W'(phase + 1'b1);
      if (rise_now) begin
        LINK.rx_serial_clock_in <= 1'b1;
      end else if (fall_now) begin
        LINK.rx_serial_clock_in <= 1'b0;
      end
    end
  end

  // bit count and sync over the frame boundary
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      host_idx <= '0;
      sent_sync <= 1'b0;
      LINK.rx_frame_sync_in <= 1'b0;
    end else begin
      if (rise_now) begin
        host_idx <= `T1RX_IDX_W'(host_idx + 1'b1);
      end
      if (fall_now) begin
        LINK.rx_frame_sync_in <= (host_idx == `T1RX_SYNC_FIRST) ||
          (host_idx == `T1RX_SYNC_LAST);
        if (host_idx == `T1RX_SYNC_FIRST) begin
          sent_sync <= 1'b1;
        end
      end
    end
  end

  // data pin synchroniser
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      data_s1 <= 1'b0;
      data_s2 <= 1'b0;
    end else begin
      data_s1 <= LINK.rx_serial_data_out;
      data_s2 <= data_s1;
    end
  end

  // falling-edge sample, read one cycle on from the second flop
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      octet <= '0;
      pay_hi <= '0;
      M_VALID <= 1'b0;
      M_FIRST <= 1'b0;
      M_DATA <= '0;
    end else begin
      M_VALID <= 1'b0;
      if (take_now && sent_sync) begin
        if (dev_idx[2:0] != 3'h7) begin
          octet[dev_idx[2:0]] <= data_s2;
        end else begin
          unique case (kind)
            OCT_FBITS: begin
              M_VALID <= 1'b1;
              M_FIRST <= 1'b1;
              M_DATA <= {8'h00, octet[6], octet[4], octet[2], octet[0]};
            end
            OCT_PAY_HI: begin
              pay_hi <= {octet[0], octet[2], octet[4], octet[6]};
            end
            OCT_PAY_LO: begin
              M_VALID <= 1'b1;
              M_FIRST <= 1'b0;
              M_DATA <= {octet[1], octet[3], octet[5], data_s2, pay_hi,
                octet[0], octet[2], octet[4], octet[6]};
            end
            OCT_FILL: begin
              M_FIRST <= M_FIRST;
            end
          endcase
        end
      end
    end
  end
endmodule : t1rx_host

// *** t1rx_link_if.sv ***
// backplane link between the framer receive end and terminal equipment
interface t1rx_link_if;
  logic rx_serial_clock_in;
  logic rx_frame_sync_in;
  logic rx_serial_data_out;

  modport dev (
    input rx_serial_clock_in,
    input rx_frame_sync_in,
    output rx_serial_data_out
  );

  modport host (
    output rx_serial_clock_in,
    output rx_frame_sync_in,
    input rx_serial_data_out
  );
endinterface : t1rx_link_if

// *** t1rx_link_sva.sv ***
// link checker for the receive backplane multiplexer
module t1rx_link_chk (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_N,
  // backplane link
  input wire logic rx_serial_clock_in,
  input wire logic rx_frame_sync_in,
  input wire logic rx_serial_data_out
);
  timeunit 1ns;
  timeprecision 1ps;

  logic seen;
  logic [13:0] cyc;
  logic [10:0] lbit;

  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);

  // first frame sync seen
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      seen <= 1'b0;
    end else if ($rose(rx_frame_sync_in)) begin
      seen <= 1'b1;
    end
  end

  // system cycles since sync rose
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      cyc <= 14'h0000;
    end else if ($rose(rx_frame_sync_in)) begin
      cyc <= 14'h0000;
    end else begin
      cyc <= cyc + 14'h0001;
    end
  end

  // link bits since sync rose
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      lbit <= 11'h000;
    end else if ($rose(rx_frame_sync_in)) begin
      lbit <= 11'h000;
    end else if ($rose(rx_serial_clock_in)) begin
      lbit <= lbit + 11'h001;
    end
  end

  AST_CLK_HIGH: assert property (
    $rose(rx_serial_clock_in) |=> rx_serial_clock_in ##1 !rx_serial_clock_in)
    else $error("link clock high phase wrong");
  AST_CLK_LOW: assert property (
    $fell(rx_serial_clock_in) |=> !rx_serial_clock_in ##1 rx_serial_clock_in)
    else $error("link clock low phase wrong");
  AST_DATA_EDGE: assert property (
    $changed(rx_serial_data_out) |-> $rose(rx_serial_clock_in))
    else $error("data changed off the rising link edge");
  AST_DATA_HOLD: assert property (
    $rose(rx_serial_clock_in) |=> $stable(rx_serial_data_out) [*3])
    else $error("data bit shorter than a link period");
  AST_SYNC_WIDTH: assert property (
    $rose(rx_frame_sync_in) |-> rx_frame_sync_in [*8] ##1 !rx_frame_sync_in)
    else $error("sync pulse not two link cycles");
  AST_SYNC_EDGE: assert property (
    $changed(rx_frame_sync_in) |-> $fell(rx_serial_clock_in))
    else $error("sync changed off the falling link edge");
  AST_SYNC_PERIOD: assert property (
    seen && $rose(rx_frame_sync_in) |-> cyc == 14'h1FFF)
    else $error("frame length not 2048 link bits");
  AST_FILL_ZERO: assert property (
    seen && $rose(rx_serial_clock_in) && lbit[7:0] >= 8'h10 &&
    lbit[7:0] <= 8'h3C |-> !rx_serial_data_out)
    else $error("filler bit not zero");
endmodule : t1rx_link_chk

// *** t1rx_params.svh ***
// constants of the receive backplane multiplexer
`ifndef T1RX_PARAMS_SVH
`define T1RX_PARAMS_SVH

// mode select
`define T1RX_MODE_H100 2'h3

// multiplexed frame layout, in octets and bits
`define T1RX_FRAME_BITS 2048
`define T1RX_IDX_W 11
`define T1RX_HDR_OCTETS 8
`define T1RX_GROUP_OCTETS 32
`define T1RX_DATA_OCTETS 24

// stream word fields: payload bit one is the msb
`define T1RX_WORD_W 12
`define T1RX_PAY_MSB 7
`define T1RX_SIG_MSB 11
`define T1RX_FILL_BIT 1'h0

// buffering
`define T1RX_FIFO_DEPTH 16

// link timing
`define T1RX_SYNC_LAG 11'h001
`define T1RX_SYNC_FIRST 11'h7FE
`define T1RX_SYNC_LAST 11'h7FF
`define T1RX_LINK_HALF 2

`endif

// *** t1rx_pkg.sv ***
// types shared by both ends of the receive backplane link
`include "t1rx_params.svh"

package t1rx_pkg;

  typedef logic [`T1RX_WORD_W-1:0] t1rx_word_type;

  typedef enum {
    OCT_FBITS,
    OCT_FILL,
    OCT_PAY_HI,
    OCT_PAY_LO
  } t1rx_octet_type;

  // octet class by position in the multiplexed frame
  function automatic t1rx_octet_type t1rx_classify(input logic [7:0] octet);
    logic [7:0] rel;
    logic [4:0] pos;
    rel = 8'(octet - 8'(`T1RX_HDR_OCTETS));
    pos = rel[4:0];
    if (octet == 8'h00) begin
      return OCT_FBITS;
    end else if (octet < 8'(`T1RX_HDR_OCTETS)) begin
      return OCT_FILL;
    end else if (pos >= 5'(`T1RX_DATA_OCTETS)) begin
      return OCT_FILL;
    end else if (!pos[0]) begin
      return OCT_PAY_HI;
    end else begin
      return OCT_PAY_LO;
    end
  endfunction : t1rx_classify

endpackage : t1rx_pkg

// *** t1rx_tb.sv ***
// self-checking bench: both link ends back to back
module t1rx_tb
  import t1rx_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_sys;
  logic rst_n;
  logic mux_en;
  logic [1:0] mode_sel;
  logic s_valid;
  logic s_ready;
  t1rx_word_type s_data;
  logic m_valid;
  logic m_first;
  t1rx_word_type m_data;
  int n_fail;
  int samples_checked;
  int cycles;
  bit armed;
  bit started;
  logic [12:0] exp_q[$];

  t1rx_link_if t1rx_link_if_i ();

  t1rx_dev t1rx_dev_i (
    .CLK_SYS(clk_sys), .RST_N(rst_n), .MUX_EN(mux_en),
    .MODE_SEL(mode_sel), .S_VALID(s_valid), .S_READY(s_ready),
    .S_DATA(s_data), .LINK(t1rx_link_if_i.dev));

  t1rx_host t1rx_host_i (
    .CLK_SYS(clk_sys), .RST_N(rst_n), .M_VALID(m_valid),
    .M_FIRST(m_first), .M_DATA(m_data), .LINK(t1rx_link_if_i.host));

  t1rx_link_chk t1rx_link_chk_i (
    .CLK_SYS(clk_sys), .RST_N(rst_n),
    .rx_serial_clock_in(t1rx_link_if_i.rx_serial_clock_in),
    .rx_frame_sync_in(t1rx_link_if_i.rx_frame_sync_in),
    .rx_serial_data_out(t1rx_link_if_i.rx_serial_data_out));

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [12:0] got, input logic [12:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : check

  task automatic end_of_test;
    $display("checks %0d errors %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_of_test

  // frame word f/i: flag bit 12 marks the framing word
  function automatic logic [12:0] wd(input int f, input int i);
    if (i == 0) begin
      return {1'h1, 8'h00, 4'(f * 5 + 3)};
    end
    return {1'h0, 12'(f * 409 + i * 37) ^ 12'hA5C};
  endfunction : wd

  // offer one word, wait for room first
  task automatic put(input logic [12:0] w);
    int k;
    k = 0;
    exp_q.push_back(w);
    while (s_ready !== 1'b1 && k < 20000) begin
      s_valid = 1'b0;
      @(negedge clk_sys);
      k++;
    end
    if (k >= 20000) begin
      check(13'h0001, 13'h0000);
    end
    s_valid = 1'b1;
    s_data = w[11:0];
    @(negedge clk_sys);
  endtask : put

  // link must stay idle and nothing be taken
  task automatic watch(input int n);
    int bad;
    bad = 0;
    repeat (n) begin
      @(negedge clk_sys);
      if (t1rx_link_if_i.rx_serial_data_out !== 1'b0 || s_ready !== 1'b0) begin
        bad++;
      end
    end
    check(13'(bad), 13'h0000);
  endtask : watch

  // recovered words in send order
  always @(negedge clk_sys) begin
    if (m_valid === 1'b1 && armed && (started || m_first === 1'b1)) begin
      started = 1'b1;
      check({m_first, m_data & (m_first ? 12'h00F : 12'hFFF)},
            exp_q.size() > 0 ? exp_q[0] : 13'h1FFF);
      if (exp_q.size() > 0) begin
        void'(exp_q.pop_front());
      end
    end
  end

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 90000) begin
      n_fail++;
      end_of_test();
    end
  end

  initial begin
    int k;
    rst_n = 1'b0;
    mux_en = 1'b0;
    mode_sel = 2'h3;
    s_valid = 1'b0;
    s_data = 12'h000;
    repeat (16) @(negedge clk_sys);
    rst_n = 1'b1;
    @(negedge clk_sys);
    for (int i = 0; i < 16; i++) begin
      put(wd(0, i));
    end
    s_valid = 1'b0;
    repeat (2) @(negedge clk_sys);
    check({12'h000, s_ready}, 13'h0000);
    for (int m = 0; m < 4; m++) begin
      mux_en = (m != 0);
      mode_sel = (m == 0) ? 2'h3 : 2'(m - 1);
      watch(8500);
    end
    mux_en = 1'b1;
    mode_sel = 2'h3;
    @(posedge t1rx_link_if_i.rx_frame_sync_in);
    armed = 1'b1;
    @(negedge clk_sys);
    for (int i = 16; i < 97; i++) begin
      put(wd(0, i));
    end
    for (int i = 0; i < 97; i++) begin
      put(wd(1, i));
    end
    s_valid = 1'b0;
    k = 0;
    while (exp_q.size() > 0 && k < 30000) begin
      @(negedge clk_sys);
      k++;
    end
    check(13'(exp_q.size()), 13'h0000);
    end_of_test();
  end
endmodule : t1rx_tb
